// file: core/dac_update_scheduler.sv
// Two-channel converter update scheduler with APB register access
//
// Chosen here: the register addresses and the APB interface to the registers.
module dac_update_scheduler
  import dac_sched_pkg::*;
(
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Timer overflow strobes
  input  dac_sched_pkg::timer_ovf_t       timer_ovf,
  // Converter input latches
  output logic      [dac_sched_pkg::WORD_W-1:0] latch0,
  output logic      [dac_sched_pkg::WORD_W-1:0] latch1
);
  import dac_sched_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // One-hot register select
  typedef enum logic [8:0] {
    SEL_NONE   = 9'h001,
    SEL_CTRL0  = 9'h002,
    SEL_LOW0   = 9'h004,
    SEL_HIGH0  = 9'h008,
    SEL_CTRL1  = 9'h010,
    SEL_LOW1   = 9'h020,
    SEL_HIGH1  = 9'h040,
    SEL_LATCH0 = 9'h080,
    SEL_LATCH1 = 9'h100
  } reg_sel_t;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Map a byte address to the register it selects
  function automatic reg_sel_t decode_sel(input logic [11:0] addr);
    case (addr)
      OFS_CTRL0:  decode_sel = SEL_CTRL0;
      OFS_LOW0:   decode_sel = SEL_LOW0;
      OFS_HIGH0:  decode_sel = SEL_HIGH0;
      OFS_CTRL1:  decode_sel = SEL_CTRL1;
      OFS_LOW1:   decode_sel = SEL_LOW1;
      OFS_HIGH1:  decode_sel = SEL_HIGH1;
      OFS_LATCH0: decode_sel = SEL_LATCH0;
      OFS_LATCH1: decode_sel = SEL_LATCH1;
      default:    decode_sel = SEL_NONE;
    endcase
  endfunction : decode_sel

  // Per-channel register selects
  function automatic reg_sel_t ctrl_sel(input int chan);
    ctrl_sel = (chan == 0) ? SEL_CTRL0 : SEL_CTRL1;
  endfunction : ctrl_sel

  function automatic reg_sel_t low_sel(input int chan);
    low_sel = (chan == 0) ? SEL_LOW0 : SEL_LOW1;
  endfunction : low_sel

  function automatic reg_sel_t high_sel(input int chan);
    high_sel = (chan == 0) ? SEL_HIGH0 : SEL_HIGH1;
  endfunction : high_sel

  // Byte lane that carries register data
  function automatic logic [7:0] byte_field(input logic [31:0] d);
    byte_field = d[7:0];
  endfunction : byte_field

  // Zero-extend a byte register to the bus width
  function automatic logic [31:0] pad_byte(input logic [7:0] b);
    pad_byte = 32'(b);
  endfunction : pad_byte

  // Zero-extend a latch to the bus width
  function automatic logic [31:0] pad_word(input logic [WORD_W-1:0] w);
    pad_word = 32'(w);
  endfunction : pad_word

  ////////////////////////////////////////////////////////////////////////////
  // Data formatting and update events
  // Justify the 16-bit pair to a 12-bit word per format code
  function automatic logic [WORD_W-1:0] justify(input logic [2:0]  fmt,
                                                input logic [15:0] pair);
    case (fmt)
      FMT_RIGHT:  justify = pair[11:0];
      FMT_SHIFT1: justify = pair[12:1];
      FMT_SHIFT2: justify = pair[13:2];
      FMT_SHIFT3: justify = pair[14:3];
      FMT_LEFT:   justify = pair[15:4];
      default:    justify = pair[11:0];
    endcase
  endfunction : justify

  // Overflow strobe that a mode selects
  function automatic logic mode_event(input update_mode_t mode,
                                      input timer_ovf_t   ovf);
    case (mode)
      MODE_TMR3: mode_event = ovf.tmr3;
      MODE_TMR4: mode_event = ovf.tmr4;
      MODE_TMR2: mode_event = ovf.tmr2;
      default:   mode_event = 1'b0;
    endcase
  endfunction : mode_event

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  reg_sel_t         sel;
  logic             setup;
  logic             access;
  logic             xfer;
  logic             wr_en;
  logic             rd_en;
  logic             hit;
  logic [7:0]       wr_byte;
  logic [31:0]      rd_word;
  logic [31:0]      next_prdata;
  chan_state_t      ch [NUM_CH];

  // Transfer phases and strobes
  assign sel     = decode_sel(paddr);
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign xfer    = access && pready;
  assign wr_en   = xfer && pwrite && pstrb[0];
  assign rd_en   = setup && !pwrite;
  assign wr_byte = byte_field(pwdata);

  // Address hit
  always_comb begin
    hit = 1'b0;
    case (sel)
      SEL_NONE: hit = 1'b0;
      default:  hit = 1'b1;
    endcase
  end

  // Handshake outputs
  assign pready  = 1'b1;
  assign pslverr = access && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, loaded in the setup cycle
  always_comb begin
    rd_word = '0;
    case (sel)
      SEL_CTRL0:  rd_word = pad_byte(ch[0].ctrl);
      SEL_LOW0:   rd_word = pad_byte(ch[0].low);
      SEL_HIGH0:  rd_word = pad_byte(ch[0].high);
      SEL_CTRL1:  rd_word = pad_byte(ch[1].ctrl);
      SEL_LOW1:   rd_word = pad_byte(ch[1].low);
      SEL_HIGH1:  rd_word = pad_byte(ch[1].high);
      SEL_LATCH0: rd_word = pad_word(ch[0].latch);
      SEL_LATCH1: rd_word = pad_word(ch[1].latch);
      default:    rd_word = '0;
    endcase
  end

  // Hold read data until the next read setup
  always_comb begin
    next_prdata = prdata;
    if (rd_en) begin
      next_prdata = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers
  // Current values
  logic [7:0]        ctrl       [NUM_CH];
  logic [7:0]        low        [NUM_CH];
  logic [7:0]        high       [NUM_CH];
  logic [WORD_W-1:0] latch      [NUM_CH];
  // Next values
  logic [7:0]        next_ctrl  [NUM_CH];
  logic [7:0]        next_low   [NUM_CH];
  logic [7:0]        next_high  [NUM_CH];
  logic [WORD_W-1:0] next_latch [NUM_CH];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // Per-channel strobes and views
      logic         wr_ctrl;
      logic         wr_low;
      logic         wr_high;
      logic         commit;
      update_mode_t mode;
      logic [2:0]   fmt;
      logic [15:0]  pair;

      // Write strobes and field views
      assign wr_ctrl = wr_en && (sel == ctrl_sel(gi));
      assign wr_low  = wr_en && (sel == low_sel(gi));
      assign wr_high = wr_en && (sel == high_sel(gi));
      assign mode    = update_mode_t'(ctrl[gi][MODE_MSB:MODE_LSB]);
      assign fmt     = ctrl[gi][FMT_MSB:FMT_LSB];
      assign pair    = {next_high[gi], next_low[gi]};

      // Control register
      always_comb begin
        next_ctrl[gi] = ctrl[gi];
        if (wr_ctrl) begin
          next_ctrl[gi] = wr_byte & CTRL_MASK;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[gi] <= CTRL_RESET;
        end else begin
          ctrl[gi] <= next_ctrl[gi];
        end
      end

      // Low data byte: always stored, never committed by itself
      always_comb begin
        next_low[gi] = low[gi];
        if (wr_low) begin
          next_low[gi] = wr_byte;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          low[gi] <= BYTE_RESET;
        end else begin
          low[gi] <= next_low[gi];
        end
      end

      // High data byte
      always_comb begin
        next_high[gi] = high[gi];
        if (wr_high) begin
          next_high[gi] = wr_byte;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          high[gi] <= BYTE_RESET;
        end else begin
          high[gi] <= next_high[gi];
        end
      end

      // Update event: high byte write or the selected overflow
      always_comb begin
        commit = 1'b0;
        case (mode)
          MODE_DEMAND: commit = wr_high;
          MODE_TMR3:   commit = mode_event(mode, timer_ovf);
          MODE_TMR4:   commit = mode_event(mode, timer_ovf);
          MODE_TMR2:   commit = mode_event(mode, timer_ovf);
          default:     commit = 1'b0;
        endcase
      end

      // Converter input latch
      always_comb begin
        next_latch[gi] = latch[gi];
        if (commit) begin
          next_latch[gi] = justify(fmt, pair);
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          latch[gi] <= LATCH_RESET;
        end else begin
          latch[gi] <= next_latch[gi];
        end
      end

      // Packed view for readback
      assign ch[gi] = '{ctrl:  ctrl[gi],
                        low:   low[gi],
                        high:  high[gi],
                        latch: latch[gi]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Converter input latches
  assign latch0 = latch[0];
  assign latch1 = latch[1];
endmodule : dac_update_scheduler

// file: core/dac_sched_pkg.sv
// Constants and types for the two-channel converter update scheduler
// Operation
// - Mode 00: high byte write updates latch
// - On-demand low byte write only stored
// - Modes 01-11 hold writes until timer overflow
// - Codes 01,10,11 pick timers three, four, two
// - Overflow copies high:low into input latch
// - Format field places word five ways
// - Second channel identical, own registers
package dac_sched_pkg;
  localparam int          NUM_CH      = 2;
  localparam int          WORD_W      = 12;
  // Byte offsets of the register words
  localparam logic [11:0] OFS_CTRL0   = 12'h000;
  localparam logic [11:0] OFS_LOW0    = 12'h004;
  localparam logic [11:0] OFS_HIGH0   = 12'h008;
  localparam logic [11:0] OFS_CTRL1   = 12'h010;
  localparam logic [11:0] OFS_LOW1    = 12'h014;
  localparam logic [11:0] OFS_HIGH1   = 12'h018;
  localparam logic [11:0] OFS_LATCH0  = 12'h020;
  localparam logic [11:0] OFS_LATCH1  = 12'h024;
  // Control register fields
  localparam int          MODE_LSB    = 3;
  localparam int          MODE_MSB    = 4;
  localparam int          FMT_LSB     = 0;
  localparam int          FMT_MSB     = 2;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_MASK   = 8'h1f;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [11:0] LATCH_RESET = 12'h000;

  typedef enum logic [1:0] {
    MODE_DEMAND = 2'h0,
    MODE_TMR3   = 2'h1,
    MODE_TMR4   = 2'h2,
    MODE_TMR2   = 2'h3
  } update_mode_t;

  // Format codes: where the 12-bit word sits in high:low
  typedef enum logic [2:0] {
    FMT_RIGHT    = 3'h0,   // word = pair[11:0]
    FMT_SHIFT1   = 3'h1,   // word = pair[12:1]
    FMT_SHIFT2   = 3'h2,   // word = pair[13:2]
    FMT_SHIFT3   = 3'h3,   // word = pair[14:3]
    FMT_LEFT     = 3'h4    // word = pair[15:4]
  } data_format_t;

  typedef struct packed {
    logic tmr2;
    logic tmr3;
    logic tmr4;
  } timer_ovf_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] low;
    logic [7:0] high;
    logic [11:0] latch;
  } chan_state_t;

endpackage : dac_sched_pkg

// file: sim/dac_update_scheduler_chk.sv
// Port assertions for the converter update scheduler
module dac_update_scheduler_chk
  import dac_sched_pkg::*;
(
  // Bus and clock
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr, latch0, latch1,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  // Timers
  input dac_sched_pkg::timer_ovf_t timer_ovf
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel & penable & pwrite & pstrb[0];
  wire cw = wr && paddr == 12'h000;
  wire lw = wr && paddr == 12'h004;
  wire hw = wr && paddr == 12'h008;
  logic [7:0] c0, l0, h0;
  wire [1:0] md = c0[4:3];
  wire ev = md == 1 ? timer_ovf.tmr3 : md == 2 ? timer_ovf.tmr4 : md == 3 & timer_ovf.tmr2;
  wire [11:0] w0 = 12'({h0, l0} >> (c0[2:0] > 4 ? 3'd0 : c0[2:0]));
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {c0, l0, h0} <= '0;
    else if (cw) c0 <= pwdata[7:0] & 8'h1f;
    else if (lw) l0 <= pwdata[7:0];
    else if (hw) h0 <= pwdata[7:0];
  a_demand_commit: assert property (hw && md == 0 |=> latch0 == w0)
    else $error("demand commit");
  a_low_held: assert property (lw && !ev |=> $stable(latch0))
    else $error("low write moved latch");
  a_timer_holds: assert property (hw && md != 0 && !ev |=> $stable(latch0))
    else $error("timer mode high write moved latch");
  a_timer_commit: assert property (ev && !cw |=> latch0 == w0)
    else $error("timer commit");
  a_fmt_left: assert property (hw && md == 0 && c0[2:0] == 4 |=> latch0 == {h0, l0[7:4]})
    else $error("left format");
  a_fmt_reserved: assert property (hw && md == 0 && c0[2:0] > 4 |=> latch0 == {h0[3:0], l0})
    else $error("reserved format");
  a_chan_apart: assert property (wr && !paddr[4] && timer_ovf == 0 |=> $stable(latch1))
    else $error("channel one moved");
  a_no_stray: assert property (!hw && !ev |=> $stable(latch0))
    else $error("stray latch change");
endmodule : dac_update_scheduler_chk
bind dac_update_scheduler dac_update_scheduler_chk chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .pslverr, .paddr, .latch0, .latch1, .pwdata, .prdata, .pstrb, .timer_ovf);

// file: sim/timer_strobe_model.sv
// Timer overflow strobe source
module timer_strobe_model
  import dac_sched_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 fire,
  input  dac_sched_pkg::timer_ovf_t pick,
  output dac_sched_pkg::timer_ovf_t ovf
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle pulse on the picked timers
  always_ff @(posedge pclk) ovf <= fire ? pick : '0;
endmodule : timer_strobe_model

// file: sim/tb_dac_update_scheduler.sv
// Self-checking bench for the converter update scheduler
module tb_dac_update_scheduler import dac_sched_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic        pready, pslverr;
  logic [11:0] paddr = '0, latch0, latch1;
  logic [31:0] pwdata = '0, prdata, seed = 32'hba64943a;
  logic [3:0]  pstrb = '0, strb = 4'hf;
  timer_ovf_t  pick = '0, ovf;
  int          ctl[2], lo[2], hi[2], lat[2], err_total, tests_run;
  int          sel[4] = '{-1, 1, 0, 2};
  always #50 pclk = ~pclk;
  dac_update_scheduler dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .timer_ovf(ovf), .latch0, .latch1);
  timer_strobe_model tmr_u (.pclk, .fire, .pick, .ovf);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int word(int c);
    int f = ctl[c] & 7;
    return ((hi[c] * 256 + lo[c]) >> (f > 4 ? 0 : f)) & 'hfff;
  endfunction : word
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic apb(logic [11:0] a, logic [31:0] d, logic w, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk) penable <= 1;
    @(posedge pclk iff pready === 1'b1) r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic chk_lat;
    @(negedge pclk);
    cmp("latch0", lat[0], latch0);
    cmp("latch1", lat[1], latch1);
  endtask : chk_lat
  task automatic wr(int c, int r, int d);
    logic [31:0] x;
    logic        e;
    apb(12'(c * 16 + r * 4), 32'(d), 1, x, e);
    if (!strb[0]) return;
    if (r == 0) ctl[c] = d & 'h1f;
    if (r == 1) lo[c] = d & 255;
    if (r == 2) hi[c] = d & 255;
    if (r == 2 && ctl[c] < 8) lat[c] = word(c);
  endtask : wr
  task automatic tm(int b);
    @(posedge pclk);
    pick <= timer_ovf_t'(3'(1 << b));
    fire <= 1;
    @(posedge pclk) fire <= 0;
    @(posedge pclk);
    for (int c = 0; c < 2; c++) if (sel[ctl[c] >> 3] == b) lat[c] = word(c);
    chk_lat;
  endtask : tm
  task automatic rd(int a, int e, logic er);
    logic [31:0] x;
    logic        s;
    apb(12'(a), '0, 0, x, s);
    cmp("rdata", e, x);
    cmp("slverr", er, s);
  endtask : rd
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    chk_lat;
    for (int i = 0; i < 16; i++) begin
      wr(i / 8, 0, i % 8);
      seed = lfsr(seed);
      wr(i / 8, 1, seed);
      chk_lat;
      wr(i / 8, 2, seed >> 8);
      chk_lat;
    end
    $display("Test formats done");
    for (int m = 1; m < 4; m++) begin
      wr(0, 0, m * 8 + m);
      wr(1, 0, (4 - m) * 8);
      seed = lfsr(seed);
      wr(0, 1, seed);
      wr(0, 2, seed >> 8);
      wr(1, 1, 0);
      wr(1, 2, seed >> 16);
      chk_lat;
      for (int b = 0; b < 3; b++) tm(b);
    end
    $display("Test timers done");
    rd(OFS_LATCH0, lat[0], 0);
    rd(OFS_LATCH1, lat[1], 0);
    rd(OFS_CTRL0, ctl[0], 0);
    wr(1, 0, 'he5);
    rd(OFS_CTRL1, ctl[1], 0);
    strb = 4'he;
    wr(1, 2, 'h77);
    strb = 4'hf;
    chk_lat;
    rd(OFS_HIGH1, hi[1], 0);
    rd('h0fc, 0, 1);
    $display("Test reads done");
    test_done;
  end
  initial begin
    #2000000;
    err_total++;
    test_done;
  end
endmodule : tb_dac_update_scheduler
